// [src/ident_page_lock_status_probe.v]
`timescale 1ns/1ps
`default_nettype none
`include "ident_lock_consts.vh"
module ident_page_lock_status_probe (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       arst_n_i,
  // Two-wire bus pins
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  // Chip-enable straps and write control
  input  wire [2:0] chip_en_i,
  input  wire       write_ctrl_i,
  // Nonvolatile write cycle handshake
  input  wire       nv_busy_i,
  output reg        nv_start_o,
  output reg        nv_is_lock_o,
  output reg        nv_is_ident_o,
  // Ident-page readback and status
  input  wire [4:0] ident_rd_addr_i,
  output reg  [7:0] ident_rd_data_o,
  output reg        ident_locked_o,
  output reg        standby_o
);
  wire scl;
  wire sda;
  reg  scl_d;
  reg  sda_d;
  reg  [2:0] phase;
  reg  [3:0] bit_cnt;
  reg  [7:0] shifter;
  reg        is_ident;
  reg        is_read;
  reg        lock_sel;
  reg  [4:0] byte_addr;
  reg        ack_drive;
  reg        pend_write;
  reg        pend_lock;
  reg        pend_any;
  reg        nv_busy_d;
  reg  [7:0] ident_mem [0:`IDP_PAGE_BYTES-1];
  reg  [7:0] stage_mem [0:`IDP_PAGE_BYTES-1];
  reg  [`IDP_PAGE_BYTES-1:0] stage_valid;
  wire       wc_s;
  wire [2:0] ce_s;
  integer i;
  genvar  g;

  // Straps and write control are pins too, so they pass the same two flops
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ce_sync
      pin_sync u_ce_sync (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .pin_i      (chip_en_i[g]),
        .sync_o     (ce_s[g])
      );
    end
  endgenerate

  pin_sync u_wc_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .pin_i      (write_ctrl_i),
    .sync_o     (wc_s)
  );

  pin_sync u_scl_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .pin_i      (scl_i),
    .sync_o     (scl)
  );

  pin_sync u_sda_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .pin_i      (sda_i),
    .sync_o     (sda)
  );

  wire start_cond = scl && scl_d && sda_d && !sda;
  wire stop_cond  = scl && scl_d && !sda_d && sda;
  wire scl_rise   = scl && !scl_d;
  wire scl_fall   = !scl && scl_d;
  wire [7:0] next_shift = {shifter[6:0], sda};
  // Select is judged on the completed byte at the eighth falling edge
  wire sel_ident = (shifter[7:4] == `IDP_DEV_TYPE);
  wire sel_match = shifter[3:1] == ce_s;
  // Array side is out of scope: only ident-page traffic is claimed
  wire sel_ok    = sel_ident && sel_match && !nv_busy_i;

  // Open drain: only ever pull low
  assign sda_o    = 1'b0;
  assign sda_oe_o = ack_drive;

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      phase      <= `PH_IDLE;
      bit_cnt    <= 4'h0;
      shifter    <= 8'h00;
      is_ident   <= 1'b0;
      is_read    <= 1'b0;
      lock_sel   <= 1'b0;
      byte_addr  <= 5'h00;
      ack_drive  <= 1'b0;
      pend_write <= 1'b0;
      pend_lock  <= 1'b0;
      pend_any   <= 1'b0;
      standby_o  <= 1'b1;
      nv_start_o <= 1'b0;
      nv_is_lock_o  <= 1'b0;
      nv_is_ident_o <= 1'b0;
      stage_valid <= {`IDP_PAGE_BYTES{1'b0}};
    end else begin
      scl_d      <= scl;
      sda_d      <= sda;
      nv_start_o <= 1'b0;
      // Committed bytes must not be written again by a later cycle
      if (nv_busy_d && !nv_busy_i)
        stage_valid <= {`IDP_PAGE_BYTES{1'b0}};
      if (start_cond) begin
        // Abandons data staged by the interrupted write without a write cycle
        phase       <= `PH_SEL;
        bit_cnt     <= 4'h0;
        ack_drive   <= 1'b0;
        pend_write  <= 1'b0;
        pend_lock   <= 1'b0;
        pend_any    <= 1'b0;
        // A polling Start during a running cycle keeps the data in flight
        if (pend_write)
          stage_valid <= {`IDP_PAGE_BYTES{1'b0}};
        standby_o   <= 1'b0;
      end else if (stop_cond) begin
        ack_drive <= 1'b0;
        phase     <= `PH_IDLE;
        standby_o <= 1'b1;
        if (pend_any && !is_read) begin
          // Only a decoded write starts a cycle, reads never do
          nv_start_o    <= 1'b1;
          nv_is_lock_o  <= pend_lock;
          nv_is_ident_o <= is_ident;
        end
        pend_any   <= 1'b0;
        pend_write <= 1'b0;
        pend_lock  <= 1'b0;
      end else if (scl_rise && phase != `PH_IDLE && phase != `PH_IGNORE) begin
        if (bit_cnt < 4'h8) begin
          shifter <= next_shift;
          bit_cnt <= bit_cnt + 4'h1;
        end
      end else if (scl_fall && phase != `PH_IDLE && phase != `PH_IGNORE) begin
        if (bit_cnt == 4'h8) begin
          bit_cnt   <= 4'h9;
          ack_drive <= 1'b0;
          case (phase)
            `PH_SEL: begin
              if (sel_ok) begin
                ack_drive <= 1'b1;
                is_ident  <= 1'b1;
                is_read   <= shifter[0];
                phase     <= shifter[0] ? `PH_IGNORE : `PH_ADDR_HI;
              end else begin
                phase <= `PH_IGNORE;
              end
            end
            `PH_ADDR_HI: begin
              lock_sel  <= shifter[`IDP_LOCK_SEL_POS];
              ack_drive <= 1'b1;
              phase     <= `PH_ADDR_LO;
            end
            `PH_ADDR_LO: begin
              byte_addr <= shifter[`IDP_BYTE_ADDR_W-1:0];
              ack_drive <= 1'b1;
              phase     <= `PH_DATA;
            end
            `PH_DATA: begin
              // Lock flag is sampled here at the ack slot
              if (ident_locked_o || wc_s) begin
                ack_drive <= 1'b0;
              end else if (lock_sel) begin
                ack_drive <= 1'b1;
                if (shifter[`IDP_LOCK_DATA_POS]) begin
                  pend_lock <= 1'b1;
                  pend_any  <= 1'b1;
                end
              end else begin
                ack_drive  <= 1'b1;
                pend_write <= 1'b1;
                pend_any   <= 1'b1;
                stage_valid[byte_addr] <= 1'b1;
                byte_addr <= byte_addr + 5'h01;
              end
            end
            default: phase <= `PH_IGNORE;
          endcase
        end else if (bit_cnt == 4'h9) begin
          ack_drive <= 1'b0;
          bit_cnt   <= 4'h0;
        end
      end
    end
  end

  // Staging registers hold data until the write cycle commits
  always @(posedge core_clk_i) begin
    if (scl_fall && phase == `PH_DATA && bit_cnt == 4'h8 && !lock_sel
        && !ident_locked_o && !wc_s)
      stage_mem[byte_addr] <= shifter;
  end

  // Nonvolatile page and lock flag: commit on completion of the cycle
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nv_busy_d <= 1'b0;
      ident_locked_o <= 1'b0;
      for (i = 0; i < `IDP_PAGE_BYTES; i = i + 1)
        ident_mem[i] <= `ERASED_BYTE;
    end else begin
      nv_busy_d <= nv_busy_i;
      if (nv_busy_d && !nv_busy_i) begin
        if (nv_is_lock_o)
          ident_locked_o <= 1'b1;
        else if (!ident_locked_o) begin
          for (i = 0; i < `IDP_PAGE_BYTES; i = i + 1)
            if (stage_valid[i])
              ident_mem[i] <= stage_mem[i];
        end
      end
    end
  end

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      ident_rd_data_o <= `ERASED_BYTE;
    else
      ident_rd_data_o <= ident_mem[ident_rd_addr_i];
  end
endmodule // ident_page_lock_status_probe
`default_nettype wire

// [src/ident_lock_consts.vh]
`ifndef IDENT_LOCK_CONSTS_VH
`define IDENT_LOCK_CONSTS_VH
// Device type nibble of the select byte for identification-page instructions
`define IDP_DEV_TYPE        4'hb
// Bit of the high address byte that picks lock (1) versus page write (0)
`define IDP_LOCK_SEL_POS    2
// Data bit that must be one in a lock instruction
`define IDP_LOCK_DATA_POS   1
// Low address bits that select the byte inside the page
`define IDP_BYTE_ADDR_W     5
`define IDP_PAGE_BYTES      32
// Delivered contents of every byte
`define ERASED_BYTE         8'hff
// Protocol phases
`define PH_IDLE             3'h0
`define PH_SEL              3'h1
`define PH_ADDR_HI          3'h2
`define PH_ADDR_LO          3'h3
`define PH_DATA             3'h4
`define PH_IGNORE           3'h5
`endif

// [src/pin_sync.v]
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser; only the second flop is visible outside
module pin_sync (
  // Clock and reset
  input  wire core_clk_i,
  input  wire arst_n_i,
  // Level in and out
  input  wire pin_i,
  output wire sync_o
);
  reg meta;
  reg sync;

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= 1'b1;
      sync <= 1'b1;
    end else begin
      meta <= pin_i;
      sync <= meta;
    end
  end

  assign sync_o = sync;
endmodule // pin_sync
`default_nettype wire

// [verif/probe_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module probe_properties (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Watched ports
  input wire logic scl_i,
  input wire logic nv_busy_i,
  input wire logic sda_oe_o,
  input wire logic nv_start_o,
  input wire logic nv_is_lock_o,
  input wire logic nv_is_ident_o,
  input wire logic ident_locked_o,
  input wire logic standby_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Ack may only move while SCL is low, or the master would see a Start or Stop
  property p_ack_rise; $rose(sda_oe_o) |-> !scl_i; endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack rise");
  property p_ack_hold; $rose(sda_oe_o) |=> sda_oe_o [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack short");
  property p_start_once; nv_start_o |=> !nv_start_o; endproperty
  a_start_once: assert property (p_start_once) else $error("start");
  property p_no_wr_lk; ident_locked_o |-> !nv_start_o; endproperty
  a_no_wr_lk: assert property (p_no_wr_lk) else $error("locked wr");
  property p_lock_ident_page_cmd; nv_start_o && nv_is_lock_o |-> nv_is_ident_o; endproperty
  a_lock_ident_page_cmd: assert property (p_lock_ident_page_cmd) else $error("lock type");
  property p_stby; $rose(standby_o) |-> scl_i; endproperty
  a_stby: assert property (p_stby) else $error("standby");
  property p_lk_rise; $rose(ident_locked_o) |-> !nv_busy_i; endproperty
  a_lk_rise: assert property (p_lk_rise) else $error("lock early");
  property p_lk_keep; ident_locked_o |=> ident_locked_o; endproperty
  a_lk_keep: assert property (p_lk_keep) else $error("lock lost");
  c_ack: cover property ($rose(sda_oe_o));
  c_lock: cover property (nv_start_o && nv_is_lock_o);
  c_locked: cover property ($rose(ident_locked_o));
endmodule // probe_properties
bind ident_page_lock_status_probe probe_properties i_probe_properties (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .nv_busy_i(nv_busy_i),
  .sda_oe_o(sda_oe_o), .nv_start_o(nv_start_o), .nv_is_lock_o(nv_is_lock_o),
  .nv_is_ident_o(nv_is_ident_o), .ident_locked_o(ident_locked_o), .standby_o(standby_o));
`default_nettype wire

// [verif/i2c_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // Clock
  input  wire logic clk_i,
  // Bus and an ack-slot strobe; SDA is released by driving one
  output var  logic scl_o = 1'b1,
  output var  logic sda_o = 1'b1,
  output var  logic ack_slot_o = 1'b0
);
  localparam int HALF = 8;
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic put_bit(input logic b, input logic slot);
    sda_o <= b;
    step(HALF);
    scl_o <= 1'b1;
    step(HALF / 2);
    ack_slot_o <= slot;
    step(1);
    ack_slot_o <= 1'b0;
    step(HALF / 2 - 1);
    scl_o <= 1'b0;
    step(1);
  endtask
  // MSB first, then SDA let go so the device can answer
  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) put_bit(b[i], 1'b0);
    put_bit(1'b1, 1'b1);
  endtask
  task automatic start();
    sda_o <= 1'b1;
    step(HALF);
    scl_o <= 1'b1;
    step(HALF);
    sda_o <= 1'b0;
    step(HALF);
    scl_o <= 1'b0;
    step(1);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    step(HALF);
    scl_o <= 1'b1;
    step(HALF);
    sda_o <= 1'b1;
    step(HALF);
  endtask
endmodule // i2c_master_model
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ident_lock_consts.vh"
module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        nv_busy = 1'b0;
  logic        wc = 1'b0;
  logic [4:0]  rd_addr = 5'h00;
  logic [31:0] seed = 32'h6a6f;
  logic [7:0]  exp_q[$];
  int          num_errors = 0;
  int          total_checks = 0;
  wire         scl, msda, slot, sda_oe, nv_start, is_lock, locked, standby;
  wire         dev_sda, is_ident;
  wire [7:0]   rd_data;
  // Pull-up on the wire: high unless someone pulls low
  wire         sda_line = msda & (sda_oe ? dev_sda : 1'b1);
  always #2 clk = ~clk;
  i2c_master_model i_i2c_master_model (.clk_i(clk), .scl_o(scl), .sda_o(msda),
    .ack_slot_o(slot));
  ident_page_lock_status_probe i_ident_page_lock_status_probe (.core_clk_i(clk),
    .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(dev_sda), .sda_oe_o(sda_oe),
    .chip_en_i(3'h5), .write_ctrl_i(wc), .nv_busy_i(nv_busy), .nv_start_o(nv_start),
    .nv_is_lock_o(is_lock), .nv_is_ident_o(is_ident), .ident_rd_addr_i(rd_addr),
    .ident_rd_data_o(rd_data), .ident_locked_o(locked), .standby_o(standby));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] b, input logic ack);
    exp_q.push_back({7'h00, ack});
    i_i2c_master_model.put_byte(b);
  endtask
  // Abort sends Start then Stop, so nothing may be committed
  task automatic cmd(input logic [7:0] hi, lo, d, input logic dack, lk, abort);
    i_i2c_master_model.start();
    xfer({`IDP_DEV_TYPE, 3'h5, 1'b0}, 1'b1);
    xfer(hi, 1'b1);
    xfer(lo, 1'b1);
    xfer(d, dack);
    if (!abort && dack) exp_q.push_back({7'h00, lk});
    if (abort) i_i2c_master_model.start();
    i_i2c_master_model.stop();
  endtask
  task automatic nv_cycle();
    repeat (4) @(posedge clk);
    nv_busy <= 1'b1;
    repeat (16) @(posedge clk);
    nv_busy <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic read_back(input logic [4:0] a, input logic [7:0] exp);
    rd_addr <= a;
    repeat (2) @(posedge clk);
    chk(rd_data, exp);
  endtask
  // Unexpected write cycles find the queue empty
  always @(posedge clk) begin
    if (slot === 1'b1 || nv_start === 1'b1) begin
      if (exp_q.size() == 0) chk(8'h01, 8'h00);
      else chk({7'h00, slot ? sda_oe : is_lock}, exp_q.pop_front());
      if (nv_start === 1'b1) chk({7'h00, is_ident}, 8'h01);
    end
  end
  initial begin
    logic [7:0] d;
    logic [4:0] a;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 32; i++) read_back(i[4:0], `ERASED_BYTE);
    seed = lfsr(seed);
    a = seed[4:0];
    d = seed[15:8];
    cmd(8'h00, {3'h0, a}, d, 1'b1, 1'b0, 1'b1);
    chk({7'h00, standby}, 8'h01);
    read_back(a, `ERASED_BYTE);
    $display("test query_unlocked done");
    cmd(8'h00, {3'h0, a}, d, 1'b1, 1'b0, 1'b0);
    nv_cycle();
    read_back(a, d);
    $display("test ident_write done");
    // Write control high: data refused, no cycle, page untouched
    wc <= 1'b1;
    cmd(8'h00, {3'h0, a}, ~d, 1'b0, 1'b0, 1'b0);
    wc <= 1'b0;
    read_back(a, d);
    $display("test write_inhibit done");
    cmd(8'h04, 8'h00, seed[23:16] | 8'h02, 1'b1, 1'b1, 1'b0);
    nv_cycle();
    chk({7'h00, locked}, 8'h01);
    $display("test lock done");
    cmd(8'h00, {3'h0, a}, ~d, 1'b0, 1'b0, 1'b1);
    cmd(8'h00, {3'h0, a}, ~d, 1'b0, 1'b0, 1'b0);
    read_back(a, d);
    $display("test query_locked done");
    chk(8'(exp_q.size()), 8'h00);
    close_out();
  end
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
